// file: design/pfs_defines.svh
// Timing, threshold and register map constants of the fault supervisor
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

`define PFS_CLK_MHZ 20
`define PFS_SOFT_START_US 8000
`define PFS_SOFT_START_CYC (`PFS_SOFT_START_US * `PFS_CLK_MHZ)
`define PFS_THERMAL_DEBOUNCE_US 14500
`define PFS_THERMAL_DEBOUNCE_CYC (`PFS_THERMAL_DEBOUNCE_US * `PFS_CLK_MHZ)
`define PFS_EXT_LATCH_DEBOUNCE_US 185
`define PFS_EXT_LATCH_DEBOUNCE_CYC (`PFS_EXT_LATCH_DEBOUNCE_US * `PFS_CLK_MHZ)
`define PFS_OVERLOAD_DEBOUNCE_US 57500
`define PFS_OVERLOAD_DEBOUNCE_CYC (`PFS_OVERLOAD_DEBOUNCE_US * `PFS_CLK_MHZ)
`define PFS_SENSE_SAMPLE_DELAY_NS 4550
`define PFS_SENSE_SAMPLE_CYC (`PFS_SENSE_SAMPLE_DELAY_NS * `PFS_CLK_MHZ / 1000)
`define PFS_SENSE_SHORT_CYCLES 11
`define PFS_SENSE_SHORT_LOW_MV 50
`define PFS_SENSE_SHORT_HIGH_MV 100

`define PFS_ADDR_CTRL 8'h00
`define PFS_ADDR_STATUS 8'h04
`define PFS_ADDR_FAULT_LOG 8'h08
`define PFS_ADDR_THRESH 8'h0c
`define PFS_CTRL_RESET 32'h0000_0001
`define PFS_LOG_OVP 0
`define PFS_LOG_OTP 1
`define PFS_LOG_EXT 2
`define PFS_LOG_OLP 3
`define PFS_LOG_SENSE_SHORT_FAULT 4

`endif

// file: design/pfs_pkg.sv
// Types of the fault supervisor
`default_nettype none
package pfs_pkg;
	typedef enum logic [1:0] {
		PS_STARTUP = 2'b00,
		PS_RUN = 2'b01,
		PS_PROTECT = 2'b11,
		PS_LOW_CURRENT = 2'b10
	} pfs_state_t;
endpackage : pfs_pkg
`default_nettype wire

// file: design/pfs_supervisor.sv
// Fault supervisor with APB status and control registers
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"

// Summary of operation
// [RQ1] After startup the current limit ramps up over 8 ms of soft start.
// [RQ2] Sense short recovers automatically; over-voltage and thermal faults latch.
// [RQ3] Overload fault recovery type is chosen by a build parameter.
// [RQ4] An auto-restart fault stops the gate at once.
// [RQ5] An auto-restart fault clears when supply falls to 11 V.
// [RQ6] Auto-restart: at 7 V the high-voltage startup path turns on.
// [RQ7] Auto-restart: switching resumes at 17 V, repeating while the fault lasts.
// [RQ8] Latched fault: at 7 V startup path turns on, fault stays set.
// [RQ9] Latched fault: at 17 V startup path turns off, gate stays off.
// [RQ10] A latched fault clears only when supply falls to 4 V.
// [RQ11] Supply above 24.5 V triggers the over-voltage fault.
// [RQ12] Thermistor pin below 1.035 V over 14.5 ms latches thermal fault.
// [RQ13] Thermistor pin below 0.7 V over 185 us latches a shutdown.
// [RQ14] Feedback above 4.6 V over 57.5 ms triggers overload fault.
// [RQ15] Current sense sampled 4.55 us after every gate turn-on.
// [RQ16] Eleven consecutive low samples trigger the sense short fault.
// [RQ17] Sense short threshold runs linearly from 50 mV to 100 mV with line.
// [RQ18] Without a fault the gate stops only below 6.5 V; the code also stops it when run_enable is cleared over APB.
// [RQ19] After any fault the gate turn-off level moves up to 11 V.
// [RQ20] Below 11 V in protection, reduced supply current until 7 V.
// [RQ21] A debounce timer restarts when its condition clears early.
// [RQ22] The sense short counter clears on any sample at or above threshold.
module pfs_supervisor
	import pfs_pkg::*;
#(
	parameter bit OVERLOAD_LATCHED = 1'b0,
	parameter int unsigned SOFT_START_CYC = `PFS_SOFT_START_CYC,
	parameter int unsigned THERMAL_DEBOUNCE_CYC = `PFS_THERMAL_DEBOUNCE_CYC,
	parameter int unsigned OVERLOAD_DEBOUNCE_CYC = `PFS_OVERLOAD_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply comparators
	input wire logic supply_above_turn_on,
	input wire logic supply_below_protect_off,
	input wire logic supply_below_low_restart,
	input wire logic supply_below_normal_lockout,
	input wire logic supply_below_latch_reset,
	input wire logic supply_above_overvoltage,
	// Thermistor pin and feedback pin comparators
	input wire logic thermistor_below_thermal,
	input wire logic thermistor_below_external,
	input wire logic feedback_above_overload,
	// Switching cycle and current sense
	input wire logic gate_turn_on,
	input wire logic [7:0] sense_mv,
	input wire logic [7:0] line_level,
	// Power stage controls
	output logic gate_enable,
	output logic high_voltage_startup_en,
	output logic reduced_supply_current,
	output logic [7:0] soft_start_level,
	output logic [7:0] sense_short_threshold
);

	localparam int CW = 21;
	localparam logic [CW-1:0] THERM_LIM = CW'(THERMAL_DEBOUNCE_CYC);
	localparam logic [CW-1:0] OLP_LIM = CW'(OVERLOAD_DEBOUNCE_CYC);
	localparam logic [CW-1:0] EXT_LIM = CW'(`PFS_EXT_LATCH_DEBOUNCE_CYC);
	localparam int unsigned SS_STEP = SOFT_START_CYC / 256;
	localparam logic [CW-1:0] SS_STEP_LIM = CW'(SS_STEP - 1);
	localparam logic [6:0] SAMPLE_LIM = 7'(`PFS_SENSE_SAMPLE_CYC);
	localparam logic [3:0] SENSE_SHORT_FAULT_LIM = 4'(`PFS_SENSE_SHORT_CYCLES);
	localparam logic [7:0] THR_LOW = 8'(`PFS_SENSE_SHORT_LOW_MV);
	localparam logic [7:0] THR_SPAN =
		8'(`PFS_SENSE_SHORT_HIGH_MV - `PFS_SENSE_SHORT_LOW_MV + 1);

	// Elaboration checks
	if (THERMAL_DEBOUNCE_CYC < 1 || THERMAL_DEBOUNCE_CYC >= (1 << CW))
		$error("thermal debounce count out of range");
	if (OVERLOAD_DEBOUNCE_CYC < 1 || OVERLOAD_DEBOUNCE_CYC >= (1 << CW))
		$error("overload debounce count out of range");
	if (SS_STEP < 1 || SS_STEP >= (1 << CW))
		$error("soft start count out of range");

	// Saturating debounce count, restarts when condition drops
	function automatic logic [CW-1:0] pfs_debounce(
		input logic [CW-1:0] cnt,
		input logic cond,
		input logic [CW-1:0] lim
	);
		if (!cond)
			return '0;
		else if (cnt == lim)
			return cnt;
		else
			return cnt + 1'b1;
	endfunction : pfs_debounce

	pfs_state_t state;
	pfs_state_t next_state;
	logic [CW-1:0] therm_cnt;
	logic [CW-1:0] ext_cnt;
	logic [CW-1:0] olp_cnt;
	logic [CW-1:0] ss_div;
	logic [6:0] sample_cnt;
	logic sample_busy;
	logic [3:0] sense_short_fault_cnt;
	logic auto_fault;
	logic latch_fault;
	logic prot_mode;
	logic run_enable;
	logic [4:0] fault_log;
	logic trip_ovp;
	logic trip_therm;
	logic trip_ext;
	logic trip_olp;
	logic trip_sense_short_fault;
	logic trip_auto;
	logic trip_latch;
	logic sample_now;
	logic [7:0] next_threshold;
	logic next_gate;
	logic apb_access;
	logic apb_done;

	// Fault triggers
	assign trip_ovp = supply_above_overvoltage; // RQ11
	assign trip_therm = thermistor_below_thermal
		&& therm_cnt == THERM_LIM; // RQ12
	assign trip_ext = thermistor_below_external && ext_cnt == EXT_LIM; // RQ13
	assign trip_olp = state == PS_RUN && feedback_above_overload
		&& olp_cnt == OLP_LIM; // RQ14
	assign sample_now = sample_busy && sample_cnt == SAMPLE_LIM; // RQ15
	assign trip_sense_short_fault = sample_now && sense_mv < sense_short_threshold
		&& sense_short_fault_cnt == SENSE_SHORT_FAULT_LIM - 4'h1; // RQ16
	assign trip_auto = trip_sense_short_fault || (!OVERLOAD_LATCHED && trip_olp); // RQ2 RQ3
	assign trip_latch = trip_ovp || trip_therm || trip_ext
		|| (OVERLOAD_LATCHED && trip_olp); // RQ2 RQ3

	// Debounce timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_cnt <= '0;
			ext_cnt <= '0;
			olp_cnt <= '0;
		end else begin
			therm_cnt <= pfs_debounce(therm_cnt, thermistor_below_thermal,
				THERM_LIM); // RQ21
			ext_cnt <= pfs_debounce(ext_cnt, thermistor_below_external,
				EXT_LIM); // RQ21
			olp_cnt <= pfs_debounce(olp_cnt,
				feedback_above_overload && state == PS_RUN, OLP_LIM); // RQ21
		end
	end

	// Sense sample timing after each gate turn-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_cnt <= '0;
			sample_busy <= 1'b0;
		end else if (gate_turn_on && state == PS_RUN) begin
			sample_cnt <= 7'h01; // RQ15
			sample_busy <= 1'b1;
		end else if (sample_now || state != PS_RUN) begin
			sample_cnt <= '0;
			sample_busy <= 1'b0;
		end else if (sample_busy) begin
			sample_cnt <= sample_cnt + 7'h01;
		end
	end

	// Consecutive low sample counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sense_short_fault_cnt <= '0;
		else if (state != PS_RUN)
			sense_short_fault_cnt <= '0;
		else if (sample_now) begin
			if (sense_mv >= sense_short_threshold)
				sense_short_fault_cnt <= '0; // RQ22
			else if (sense_short_fault_cnt != SENSE_SHORT_FAULT_LIM)
				sense_short_fault_cnt <= sense_short_fault_cnt + 4'h1; // RQ16
		end
	end

	// Line dependent sense short threshold
	always_comb begin
		next_threshold = THR_LOW
			+ 8'((16'(line_level) * 16'(THR_SPAN)) >> 8); // RQ17
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sense_short_threshold <= THR_LOW;
		else
			sense_short_threshold <= next_threshold; // RQ17
	end

	// Auto-restart fault flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			auto_fault <= 1'b0;
		else if (trip_auto)
			auto_fault <= 1'b1;
		else if (state == PS_PROTECT && supply_below_protect_off)
			auto_fault <= 1'b0; // RQ5
	end

	// Latched fault flag, cleared only at the latch reset level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			latch_fault <= 1'b0;
		else if (trip_latch)
			latch_fault <= 1'b1;
		else if (supply_below_latch_reset)
			latch_fault <= 1'b0; // RQ10
	end

	// Protection mode raises the gate turn-off level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prot_mode <= 1'b0;
		else if (trip_auto || trip_latch)
			prot_mode <= 1'b1; // RQ19
		else if (state == PS_STARTUP && next_state == PS_RUN)
			prot_mode <= 1'b0;
	end

	// Supply sequencing
	always_comb begin
		next_state = state;
		case (state)
			PS_STARTUP: begin
				if (supply_above_turn_on) begin
					if (latch_fault)
						next_state = PS_LOW_CURRENT; // RQ9
					else
						next_state = PS_RUN; // RQ7
				end
			end
			PS_RUN: begin
				if (trip_auto || trip_latch || auto_fault || latch_fault)
					next_state = PS_PROTECT; // RQ4
				else if (supply_below_normal_lockout)
					next_state = PS_STARTUP; // RQ18
			end
			PS_PROTECT: begin
				if (supply_below_protect_off)
					next_state = PS_LOW_CURRENT; // RQ20
			end
			PS_LOW_CURRENT: begin
				if (supply_below_low_restart)
					next_state = PS_STARTUP; // RQ6 RQ8
			end
			default: next_state = PS_STARTUP;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= PS_STARTUP;
		else
			state <= next_state;
	end

	// Power stage controls
	always_comb begin
		next_gate = next_state == PS_RUN && run_enable; // RQ4 RQ18
		if (prot_mode && supply_below_protect_off)
			next_gate = 1'b0; // RQ19
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_enable <= 1'b0;
			high_voltage_startup_en <= 1'b1;
			reduced_supply_current <= 1'b0;
		end else begin
			gate_enable <= next_gate;
			high_voltage_startup_en <= next_state == PS_STARTUP; // RQ6 RQ8 RQ9
			reduced_supply_current <= next_state == PS_LOW_CURRENT; // RQ20
		end
	end

	// Soft-start ramp of the current limit level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_div <= '0;
			soft_start_level <= '0;
		end else if (state != PS_RUN) begin
			ss_div <= '0;
			soft_start_level <= '0;
		end else if (soft_start_level != 8'hff) begin
			if (ss_div == SS_STEP_LIM) begin
				ss_div <= '0;
				soft_start_level <= soft_start_level + 8'h01; // RQ1
			end else begin
				ss_div <= ss_div + 1'b1;
			end
		end
	end

	// APB access, one wait state
	assign apb_access = psel && penable && !pready;
	assign apb_done = psel && penable && pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= apb_access;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (apb_access) begin
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
				`PFS_ADDR_CTRL: prdata <= {31'h0, run_enable};
				`PFS_ADDR_STATUS: prdata <= {12'h0, sense_short_fault_cnt, soft_start_level,
					1'b0, reduced_supply_current, high_voltage_startup_en,
					gate_enable, latch_fault, auto_fault, state};
				`PFS_ADDR_FAULT_LOG: prdata <= {27'h0, fault_log};
				`PFS_ADDR_THRESH: prdata <= {24'h0, sense_short_threshold};
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_enable <= 1'(`PFS_CTRL_RESET);
		else if (apb_done && pwrite && paddr == `PFS_ADDR_CTRL)
			run_enable <= pwdata[0];
	end

	// Fault history, write one to clear, new events win
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_log <= '0;
		else begin
			for (int i = 0; i < 5; i++) begin
				if (apb_done && pwrite && paddr == `PFS_ADDR_FAULT_LOG
					&& pwdata[i])
					fault_log[i] <= 1'b0;
			end
			if (trip_ovp)
				fault_log[`PFS_LOG_OVP] <= 1'b1;
			if (trip_therm)
				fault_log[`PFS_LOG_OTP] <= 1'b1;
			if (trip_ext)
				fault_log[`PFS_LOG_EXT] <= 1'b1;
			if (trip_olp)
				fault_log[`PFS_LOG_OLP] <= 1'b1;
			if (trip_sense_short_fault)
				fault_log[`PFS_LOG_SENSE_SHORT_FAULT] <= 1'b1;
		end
	end

endmodule : pfs_supervisor
`default_nettype wire

// file: sim/pfs_supervisor_chk.sv
// Port checks of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor_chk (
	// Clock, reset, bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Supply comparators
	input wire logic supply_above_turn_on,
	input wire logic supply_below_low_restart,
	input wire logic supply_below_normal_lockout,
	input wire logic supply_above_overvoltage,
	// Stage controls
	input wire logic gate_enable,
	input wire logic high_voltage_startup_en,
	input wire logic reduced_supply_current
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_bus_wait: assert property (psel && penable && !pready |=>
		pready ##1 !pready) else $error("bus answer late");
	chk_ovp_gate: assert property (
		supply_above_overvoltage |=> !gate_enable) else $error("gate on");
	chk_gate_start: assert property (
		$rose(gate_enable) |-> $past(supply_above_turn_on))
		else $error("gate rose early");
	chk_hv_charge: assert property (
		$rose(high_voltage_startup_en) |-> $past(supply_below_low_restart))
		else $error("hv rose early");
	chk_hv_stop: assert property (
		$fell(high_voltage_startup_en) |-> $past(supply_above_turn_on))
		else $error("hv fell early");
	chk_low_gate: assert property (
		reduced_supply_current |-> !gate_enable) else $error("gate in low");
	chk_low_exit: assert property (
		reduced_supply_current && supply_below_low_restart |=>
		!reduced_supply_current) else $error("low mode stuck");
	chk_lockout_stop: assert property (
		gate_enable && supply_below_normal_lockout |=> !gate_enable)
		else $error("gate on below lockout");
endmodule : pfs_supervisor_chk
`default_nettype wire

// file: sim/pfs_stage_model.sv
// Power stage, supply and thermistor model
`timescale 1ns/1ps
`default_nettype none
module pfs_stage_model (
	// Bench controls
	input wire logic pclk,
	input wire logic [9:0] vdd_dv,
	input wire logic [10:0] rt_mv,
	input wire logic fb_high,
	input wire logic shorted,
	input wire logic gate_enable,
	// Comparator results
	output logic supply_above_turn_on,
	output logic supply_below_protect_off,
	output logic supply_below_low_restart,
	output logic supply_below_normal_lockout,
	output logic supply_below_latch_reset,
	output logic supply_above_overvoltage,
	output logic thermistor_below_thermal,
	output logic thermistor_below_external,
	output logic feedback_above_overload,
	// Switching events
	output logic gate_turn_on,
	output logic [7:0] sense_mv
);
	logic [6:0] phase = 7'h00;
	always_ff @(posedge pclk) begin
		phase <= (phase == 7'd99) ? 7'h00 : phase + 7'd1;
	end
	assign gate_turn_on = gate_enable && phase == 7'h00;
	assign sense_mv = shorted ? 8'h0a : 8'hc8;
	assign supply_above_turn_on = vdd_dv >= 10'd170;
	assign supply_below_protect_off = vdd_dv <= 10'd110;
	assign supply_below_low_restart = vdd_dv <= 10'd70;
	assign supply_below_normal_lockout = vdd_dv < 10'd65;
	assign supply_below_latch_reset = vdd_dv <= 10'd40;
	assign supply_above_overvoltage = vdd_dv > 10'd245;
	assign thermistor_below_thermal = rt_mv < 11'd1035;
	assign thermistor_below_external = rt_mv < 11'd700;
	assign feedback_above_overload = fb_high;
endmodule : pfs_stage_model
`default_nettype wire

// file: sim/testbench.sv
// Bench of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, line_level, soft_start_level, sense_short_threshold;
	logic [31:0] pwdata, prdata, rd;
	logic supply_above_turn_on, supply_below_protect_off;
	logic supply_below_low_restart, supply_below_normal_lockout;
	logic supply_below_latch_reset, supply_above_overvoltage;
	logic thermistor_below_thermal, thermistor_below_external;
	logic feedback_above_overload, gate_turn_on, gate_enable;
	logic high_voltage_startup_en, reduced_supply_current;
	logic [7:0] sense_mv;
	logic [9:0] vdd_dv;
	logic [10:0] rt_mv;
	logic fb_high, shorted;
	int fails = 0;
	int samples_checked = 0;
	pfs_supervisor #(.THERMAL_DEBOUNCE_CYC(4000),
		.OVERLOAD_DEBOUNCE_CYC(60)) DUT (.*);
	pfs_stage_model u_stage (.*);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt
	task automatic drv(input int v, r, f, s);
		@(posedge pclk);
		vdd_dv <= 10'(v);
		rt_mv <= 11'(r);
		fb_high <= 1'(f);
		shorted <= 1'(s);
	endtask : drv
	task automatic apb(input logic wr, input logic [7:0] a, input int d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic trip(input int r, f, n);
		drv(170, r, f, 0);
		wt(n);
		chk("gate held", 1, gate_enable);
		wt(8);
		chk("gate tripped", 0, gate_enable);
		drv(170, 1500, 0, 0);
	endtask : trip
	task automatic cycle_supply(input logic clear_all);
		drv(100, 1500, 0, 0);
		wt(4);
		chk("reduced", 1, reduced_supply_current);
		chk("gate off", 0, gate_enable);
		drv(70, 1500, 0, 0);
		wt(4);
		chk("hv on", 1, high_voltage_startup_en);
		chk("reduced end", 0, reduced_supply_current);
		if (clear_all) begin
			drv(40, 1500, 0, 0);
			wt(2);
		end
		drv(170, 1500, 0, 0);
		wt(20);
		chk("hv off", 0, high_voltage_startup_en);
	endtask : cycle_supply
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#2000000;
		fails++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, fb_high, shorted} = '0;
		paddr = '0;
		pwdata = '0;
		line_level = 8'hff;
		vdd_dv = '0;
		rt_mv = 11'd1500;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wt(1);
		chk("hv reset", 1, high_voltage_startup_en);
		apb(0, 8'h0c, 0);
		chk("threshold", 32'h64, rd);
		chk("threshold pin", 32'h64, sense_short_threshold);
		@(posedge pclk);
		line_level <= 8'h00;
		wt(2);
		chk("threshold low", 32'h32, sense_short_threshold);
		@(posedge pclk);
		line_level <= 8'hff;
		apb(1, 8'h40, 1);
		chk("unmapped", 1, er);
		apb(1, 8'h00, 1);
		drv(170, 1500, 0, 0);
		wt(20);
		chk("gate on", 1, gate_enable);
		wt(1900);
		chk("soft level", 3, soft_start_level);
		apb(0, 8'h04, 0);
		chk("status", 32'h311, rd & 32'hf_ffff);
		apb(1, 8'h00, 0);
		wt(2);
		chk("gate disabled", 0, gate_enable);
		apb(1, 8'h00, 1);
		wt(2);
		chk("gate enabled", 1, gate_enable);
		drv(100, 1500, 0, 0);
		wt(4);
		chk("gate at 10V", 1, gate_enable);
		drv(60, 1500, 0, 0);
		wt(4);
		chk("gate at 6V", 0, gate_enable);
		drv(170, 1500, 0, 1);
		wt(950);
		drv(170, 1500, 0, 0);
		wt(150);
		drv(170, 1500, 0, 1);
		wt(950);
		chk("short early", 1, gate_enable);
		wt(250);
		chk("short trip", 0, gate_enable);
		cycle_supply(0);
		chk("auto restart", 1, gate_enable);
		apb(0, 8'h08, 0);
		chk("log", 32'h10, rd);
		apb(1, 8'h08, 32'h1f);
		apb(0, 8'h08, 0);
		chk("log clear", 0, rd);
		trip(1500, 1, 58);
		cycle_supply(0);
		chk("overload auto", 1, gate_enable);
		drv(170, 1000, 0, 0);
		wt(3998);
		drv(170, 1500, 0, 0);
		trip(1000, 0, 3996);
		cycle_supply(0);
		chk("thermal held", 0, gate_enable);
		cycle_supply(1);
		chk("thermal clear", 1, gate_enable);
		trip(500, 0, 3698);
		cycle_supply(0);
		chk("external held", 0, gate_enable);
		cycle_supply(1);
		chk("external clear", 1, gate_enable);
		drv(250, 1500, 0, 0);
		wt(1);
		chk("ovp", 0, gate_enable);
		cycle_supply(0);
		chk("ovp held", 0, gate_enable);
		cycle_supply(1);
		chk("ovp clear", 1, gate_enable);
		stop_test();
	end
endmodule : testbench
bind pfs_supervisor pfs_supervisor_chk u_chk (.*);
`default_nettype wire
